// ---- src/jlp_pkg.sv ----
package jlp_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] JLP_OFS_CTRL = 8'h00;
  localparam logic [7:0] JLP_OFS_MFLEN = 8'h04;
  localparam logic [7:0] JLP_OFS_DID = 8'h08;
  localparam logic [7:0] JLP_OFS_STATUS = 8'h0c;
  localparam logic [7:0] JLP_OFS_PARAM_A = 8'h10;
  localparam logic [7:0] JLP_OFS_PARAM_B = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int JLP_CTRL_MODE_LSB = 0;
  localparam int JLP_CTRL_SCR_BIT = 4;
  localparam int JLP_CTRL_START_BIT = 7;
  localparam int JLP_STS_VALID_BIT = 0;
  localparam int JLP_STS_ENC64_BIT = 1;
  localparam int JLP_STS_BUSY_BIT = 2;
  localparam int JLP_STS_SKIP_BIT = 3;
  localparam int JLP_STS_CHK_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] JLP_RST_MODE = 4'h0;
  localparam logic JLP_RST_SCR = 1'b0;
  localparam logic [7:0] JLP_RST_MFLEN = 8'h1f;
  localparam logic [7:0] JLP_RST_DID = 8'h00;

  // ----------------------------------------------------------------
  // Fixed link parameter values
  // ----------------------------------------------------------------
  localparam logic [3:0] JLP_ILAS_OCTETS = 4'he;
  localparam logic [3:0] JLP_ADJCNT = 4'h0;
  localparam logic JLP_ADJDIR = 1'b0;
  localparam logic JLP_PHADJ = 1'b0;
  localparam logic [3:0] JLP_BID = 4'h0;
  localparam logic [1:0] JLP_CS = 2'h0;
  localparam logic [4:0] JLP_CF = 5'h00;
  localparam logic JLP_HD = 1'b0;
  localparam logic [2:0] JLP_JESDV = 3'h1;
  localparam logic [2:0] JLP_SUBCLASSV = 3'h1;
  localparam logic [7:0] JLP_RES1 = 8'h00;
  localparam logic [7:0] JLP_RES2 = 8'h00;
  localparam logic [3:0] JLP_EMB = 4'h1;
  localparam logic [11:0] JLP_K64_NUM = 12'h100;

  // ----------------------------------------------------------------
  // Mode table
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic enc64;
    logic [4:0] n;
    logic [4:0] np;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] f;
    logic [3:0] s;
    logic [9:0] r16;
  } jlp_mode_s;

  // Lane rate factor kept in sixteenths to hold 12.375 and 6.1875 exactly
  function automatic jlp_mode_s jlp_mode_lookup(input logic [3:0] mode);
    jlp_mode_s p;
    p = '0;
    case (mode)
      4'h0: p = '{1'b1, 1'b0, 5'h0c, 5'h0c, 4'h8, 4'h8, 4'h8, 4'h5, 10'h080};
      4'h1: p = '{1'b1, 1'b0, 5'h0c, 5'h0c, 4'h6, 4'h4, 4'h2, 4'h2, 10'h0a0};
      4'h2: p = '{1'b1, 1'b0, 5'h08, 5'h08, 4'h4, 4'h4, 4'h1, 4'h1, 10'h0a0};
      4'h3: p = '{1'b1, 1'b0, 5'h0a, 5'h0a, 4'h4, 4'h4, 4'h5, 4'h4, 10'h0c8};
      4'h4: p = '{1'b1, 1'b1, 5'h0c, 5'h0c, 4'h3, 4'h4, 4'h2, 4'h1, 10'h108};
      4'h5: p = '{1'b1, 1'b1, 5'h08, 5'h08, 4'h2, 4'h4, 4'h2, 4'h1, 10'h108};
      4'h6: p = '{1'b1, 1'b1, 5'h0c, 5'h0c, 4'h6, 4'h4, 4'h2, 4'h2, 10'h084};
      4'h7: p = '{1'b1, 1'b1, 5'h08, 5'h08, 4'h4, 4'h4, 4'h1, 4'h1, 10'h084};
      4'h8: p = '{1'b1, 1'b1, 5'h0c, 5'h0c, 4'h4, 4'h4, 4'h3, 4'h2, 10'h0c6};
      4'h9: p = '{1'b1, 1'b0, 5'h08, 5'h08, 4'h8, 4'h4, 4'h1, 4'h2, 10'h050};
      4'ha: p = '{1'b1, 1'b0, 5'h0a, 5'h0a, 4'h8, 4'h8, 4'h5, 4'h4, 10'h064};
      4'he: p = '{1'b1, 1'b1, 5'h0c, 5'h0c, 4'h8, 4'h8, 4'h3, 4'h2, 10'h063};
      default: p = '0;
    endcase
    return p;
  endfunction

endpackage

// ---- src/jlp_link_param.sv ----
// What this block does
// - One written mode select derives all link parameters except user settings.
// - Lane rate factor R drives the serializer PLL multiplier output.
// - Extended multiblock count fixed at one, unused for 8B/10B.
// - In 8B/10B mode the alignment parameter octets are sent per lane.
// - 64B/66B sends no alignment sequence; same transport parameters kept.
// - Adjustment amount and direction fields always zero.
// - Bank, control words, density, reserved zero; revision and subclass one.
// - Control bits per sample field always zero in alignment octets.
// - Device identifier and scrambler enable reported as written.
// - Converter count comes from the mode, not the channel count.
// - Each lane sends its own lane identifier.
// - Sample resolution and total bits per sample both reported from mode.
// - Frames per multiframe field comes straight from the written register.
// - Checksum is sum of all other fields modulo 256.
// - 64B/66B multiframe length is 8 x 32 x E / F, not programmable.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Octet FIFO with a registered head
// ------------------------------------------------------------------
module jlp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic [WIDTH-1:0] in_data, // Write data
  input wire logic in_valid, // Write request
  output logic in_ready, // Room for a word
  output logic [WIDTH-1:0] out_data, // Head word
  output logic out_valid, // Head word present
  input wire logic out_ready // Head consumed
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [WIDTH-1:0] head_reg;
  logic head_valid_reg;
  logic push;
  logic load;

  // Head register keeps the top-level outputs straight from flip-flops
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign load = (count_reg != '0) && (!head_valid_reg || out_ready);
  assign out_data = head_reg;
  assign out_valid = head_valid_reg;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      head_reg <= '0;
      head_valid_reg <= 1'b0;
    end else if (load) begin
      head_reg <= mem[rd_ptr_reg];
      head_valid_reg <= 1'b1;
    end else if (out_ready) begin
      head_valid_reg <= 1'b0;
    end
  end
endmodule // jlp_fifo

// ------------------------------------------------------------------
// Link parameter configuration and alignment octet generator
// ------------------------------------------------------------------
module jlp_link_param (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic [7:0] ilas_octet, // Alignment octet
  output logic [2:0] ilas_lane, // Lane of octet
  output logic ilas_last, // Last octet of lane
  output logic ilas_valid, // Octet present
  input wire logic ilas_ready, // Octet taken
  output logic [9:0] pll_mult_x16, // Lane rate factor in sixteenths
  output logic [3:0] lane_count, // Active lanes
  output logic enc_64b66b, // 64B/66B selected
  output logic mode_valid // Mode is supported
);
  typedef enum logic [0:0] {JLP_IDLE, JLP_SEND} jlp_state_e;

  jlp_state_e state_reg;
  logic [3:0] link_mode_select_reg;
  logic scr_reg;
  logic [7:0] multiframe_len_minus_one_reg;
  logic [7:0] did_reg;
  logic skipped_reg;
  logic [2:0] lane_reg;
  logic [3:0] oct_reg;
  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [9:0] pll_mult_reg;
  logic [3:0] lane_count_reg;
  logic enc_reg;
  logic mode_valid_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req_new;
  logic wr_accept;
  logic busy;
  logic wr_ok;
  logic sel_ctrl;
  logic sel_mflen;
  logic sel_did;
  logic start_req;

  // Request is taken one cycle after it appears, while waitrequest is low
  assign req_new = (avs_read || avs_write) && waitrequest_reg;
  assign wr_accept = avs_write && !waitrequest_reg;
  assign busy = (state_reg != JLP_IDLE);
  // Config stays frozen while the sequencer pushes octets into the FIFO
  assign wr_ok = wr_accept && avs_byteenable[0] && !busy;
  assign sel_ctrl = (avs_address[7:2] == jlp_pkg::JLP_OFS_CTRL[7:2]);
  assign sel_mflen = (avs_address[7:2] == jlp_pkg::JLP_OFS_MFLEN[7:2]);
  assign sel_did = (avs_address[7:2] == jlp_pkg::JLP_OFS_DID[7:2]);
  assign start_req = wr_ok && sel_ctrl && avs_writedata[jlp_pkg::JLP_CTRL_START_BIT];

  // ----------------------------------------------------------------
  // Derived parameters
  // ----------------------------------------------------------------
  jlp_pkg::jlp_mode_s p;
  assign p = jlp_pkg::jlp_mode_lookup(link_mode_select_reg);

  logic [7:0] l_m1;
  logic [7:0] f_m1;
  logic [7:0] m_m1;
  logic [7:0] n_m1;
  logic [7:0] np_m1;
  logic [7:0] s_m1;
  logic [3:0] f_div;
  logic [11:0] k64;
  logic [8:0] k_eff_m1;
  assign l_m1 = {4'h0, p.l} - 8'h01;
  assign f_m1 = {4'h0, p.f} - 8'h01;
  assign m_m1 = {4'h0, p.m} - 8'h01;
  assign n_m1 = {3'h0, p.n} - 8'h01;
  assign np_m1 = {3'h0, p.np} - 8'h01;
  assign s_m1 = {4'h0, p.s} - 8'h01;
  assign f_div = (p.f == 4'h0) ? 4'h1 : p.f;
  // 64B/66B frame count from E and F
  assign k64 = (jlp_pkg::JLP_K64_NUM * 12'(jlp_pkg::JLP_EMB)) / 12'(f_div);
  assign k_eff_m1 = p.enc64 ? 9'(k64 - 12'h001) : {1'b0, multiframe_len_minus_one_reg};

  // ----------------------------------------------------------------
  // Alignment octets
  // ----------------------------------------------------------------
  logic [7:0] base_sum;
  logic [7:0] lid;
  logic [7:0] chk;
  logic [7:0] oct [0:13];
  logic [7:0] cur_octet;

  assign lid = {5'h00, lane_reg};
  assign base_sum = did_reg + 8'(jlp_pkg::JLP_ADJCNT) + 8'(jlp_pkg::JLP_BID)
    + 8'(jlp_pkg::JLP_ADJDIR) + 8'(jlp_pkg::JLP_PHADJ) + 8'(scr_reg) + l_m1 + f_m1
    + multiframe_len_minus_one_reg + m_m1 + 8'(jlp_pkg::JLP_CS) + n_m1
    + 8'(jlp_pkg::JLP_SUBCLASSV) + np_m1 + 8'(jlp_pkg::JLP_JESDV) + s_m1
    + 8'(jlp_pkg::JLP_HD) + 8'(jlp_pkg::JLP_CF) + jlp_pkg::JLP_RES1 + jlp_pkg::JLP_RES2;
  // only identifier and checksum vary by lane
  assign chk = base_sum + lid;

  assign oct[0] = did_reg;
  assign oct[1] = {jlp_pkg::JLP_ADJCNT, jlp_pkg::JLP_BID};
  assign oct[2] = {1'b0, jlp_pkg::JLP_ADJDIR, jlp_pkg::JLP_PHADJ, lid[4:0]};
  assign oct[3] = {scr_reg, 2'b00, l_m1[4:0]};
  assign oct[4] = f_m1;
  assign oct[5] = multiframe_len_minus_one_reg;
  assign oct[6] = m_m1;
  assign oct[7] = {jlp_pkg::JLP_CS, 1'b0, n_m1[4:0]};
  assign oct[8] = {jlp_pkg::JLP_SUBCLASSV, np_m1[4:0]};
  assign oct[9] = {jlp_pkg::JLP_JESDV, s_m1[4:0]};
  assign oct[10] = {jlp_pkg::JLP_HD, 2'b00, jlp_pkg::JLP_CF};
  assign oct[11] = jlp_pkg::JLP_RES1;
  assign oct[12] = jlp_pkg::JLP_RES2;
  assign oct[13] = chk;
  assign cur_octet = oct[oct_reg];

  // ----------------------------------------------------------------
  // Octet sequencer
  // ----------------------------------------------------------------
  logic fifo_in_ready;
  logic push_ok;
  logic oct_last;
  logic lane_last;

  assign push_ok = (state_reg == JLP_SEND) && fifo_in_ready;
  assign oct_last = (oct_reg == jlp_pkg::JLP_ILAS_OCTETS - 4'h1);
  assign lane_last = ({1'b0, lane_reg} == p.l - 4'h1);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= JLP_IDLE;
      lane_reg <= 3'h0;
      oct_reg <= 4'h0;
      skipped_reg <= 1'b0;
    end else begin
      case (state_reg)
        JLP_IDLE: begin
          lane_reg <= 3'h0;
          oct_reg <= 4'h0;
          if (start_req && p.valid && p.enc64) begin
            skipped_reg <= 1'b1;
          end else if (start_req && p.valid) begin
            skipped_reg <= 1'b0;
            state_reg <= JLP_SEND;
          end
        end
        JLP_SEND: begin
          if (push_ok && oct_last) begin
            oct_reg <= 4'h0;
            lane_reg <= lane_reg + 3'h1;
            if (lane_last) begin
              state_reg <= JLP_IDLE;
            end
          end else if (push_ok) begin
            oct_reg <= oct_reg + 4'h1;
          end
        end
        default: begin
          state_reg <= JLP_IDLE;
        end
      endcase
    end
  end

  // Back-pressure from ilas_ready stalls the sequencer via fifo_in_ready
  logic [11:0] fifo_out;
  jlp_fifo #(
    .WIDTH(12),
    .DEPTH(8)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_data({oct_last, lane_reg, cur_octet}),
    .in_valid(state_reg == JLP_SEND),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(ilas_valid),
    .out_ready(ilas_ready)
  );
  assign ilas_octet = fifo_out[7:0];
  assign ilas_lane = fifo_out[10:8];
  assign ilas_last = fifo_out[11];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link_mode_select_reg <= jlp_pkg::JLP_RST_MODE;
      scr_reg <= jlp_pkg::JLP_RST_SCR;
      multiframe_len_minus_one_reg <= jlp_pkg::JLP_RST_MFLEN;
      did_reg <= jlp_pkg::JLP_RST_DID;
    end else begin
      if (wr_ok && sel_ctrl) begin
        link_mode_select_reg <= avs_writedata[jlp_pkg::JLP_CTRL_MODE_LSB +: 4];
        scr_reg <= avs_writedata[jlp_pkg::JLP_CTRL_SCR_BIT];
      end
      if (wr_ok && sel_mflen) begin
        multiframe_len_minus_one_reg <= avs_writedata[7:0];
      end
      if (wr_ok && sel_did) begin
        did_reg <= avs_writedata[7:0];
      end
    end
  end

  logic [31:0] status_word;
  logic [31:0] param_a;
  logic [31:0] param_b;
  logic [31:0] rd_mux;

  assign status_word = ({31'h0, p.valid} << jlp_pkg::JLP_STS_VALID_BIT)
    | ({31'h0, p.enc64} << jlp_pkg::JLP_STS_ENC64_BIT)
    | ({31'h0, busy} << jlp_pkg::JLP_STS_BUSY_BIT)
    | ({31'h0, skipped_reg} << jlp_pkg::JLP_STS_SKIP_BIT)
    | ({24'h0, base_sum} << jlp_pkg::JLP_STS_CHK_LSB);
  assign param_a = {3'h0, p.np, 3'h0, p.n, p.s, p.f, p.m, p.l};
  assign param_b = {jlp_pkg::JLP_EMB, 3'h0, k_eff_m1, 6'h00, p.r16};
  assign rd_mux = (avs_address[7:2] == jlp_pkg::JLP_OFS_CTRL[7:2]) ?
      {27'h0, scr_reg, link_mode_select_reg} :
    (avs_address[7:2] == jlp_pkg::JLP_OFS_MFLEN[7:2]) ? {24'h0, multiframe_len_minus_one_reg} :
    (avs_address[7:2] == jlp_pkg::JLP_OFS_DID[7:2]) ? {24'h0, did_reg} :
    (avs_address[7:2] == jlp_pkg::JLP_OFS_STATUS[7:2]) ? status_word :
    (avs_address[7:2] == jlp_pkg::JLP_OFS_PARAM_A[7:2]) ? param_a :
    (avs_address[7:2] == jlp_pkg::JLP_OFS_PARAM_B[7:2]) ? param_b : 32'h0;

  // Fixed one-cycle stall per access
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h0;
    end else begin
      waitrequest_reg <= !req_new;
      if (req_new && avs_read) begin
        readdata_reg <= rd_mux;
      end
    end
  end

  // PLL multiplier from lane rate factor
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pll_mult_reg <= 10'h000;
      lane_count_reg <= 4'h0;
      enc_reg <= 1'b0;
      mode_valid_reg <= 1'b0;
    end else begin
      pll_mult_reg <= p.r16;
      lane_count_reg <= p.l;
      enc_reg <= p.enc64;
      mode_valid_reg <= p.valid;
    end
  end

  assign avs_waitrequest = waitrequest_reg;
  assign avs_readdata = readdata_reg;
  assign pll_mult_x16 = pll_mult_reg;
  assign lane_count = lane_count_reg;
  assign enc_64b66b = enc_reg;
  assign mode_valid = mode_valid_reg;
endmodule // jlp_link_param

// ---- testbench/jlp_link_param_assertions.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module jlp_link_param_chk (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic avs_waitrequest, // Stall
  input wire logic [7:0] ilas_octet, // Octet
  input wire logic [2:0] ilas_lane, // Lane
  input wire logic ilas_last, // Last octet
  input wire logic ilas_valid, // Present
  input wire logic ilas_ready, // Taken
  input wire logic [9:0] pll_mult_x16, // Rate factor
  input wire logic [3:0] lane_count, // Lanes
  input wire logic enc_64b66b // Long encoding
);
  logic [3:0] idx_reg;
  logic [3:0] idx_next;
  wire take = ilas_valid && ilas_ready;

  // Octet position inside the lane's set
  assign idx_next = ilas_last ? 4'h0 : idx_reg + 4'h1;
  always_ff @(posedge clk_sys) begin
    if (reset) idx_reg <= 4'h0;
    else if (take) idx_reg <= idx_next;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_answer_a: assert property (s_req |=> s_ans) else $error("bus answer not one wait");
  ilas_hold_a: assert property (ilas_valid && !ilas_ready
    |=> ilas_valid && $stable({ilas_octet, ilas_lane, ilas_last})) else $error("octet dropped while stalled");
  no_align64_a: assert property (enc_64b66b |-> !ilas_valid) else $error("octets in long mode");
  lane_range_a: assert property (ilas_valid |-> {1'h0, ilas_lane} < lane_count)
    else $error("lane out of range");
  zero_oct_a: assert property (ilas_valid && idx_reg inside {4'h1, 4'ha, 4'hb, 4'hc}
    |-> ilas_octet == 8'h00) else $error("fixed octet not zero");
  lid_oct_a: assert property (ilas_valid && idx_reg == 4'h2 |-> ilas_octet == {5'h00, ilas_lane})
    else $error("lane id octet wrong");
  rev_oct_a: assert property (ilas_valid && idx_reg inside {4'h8, 4'h9} |-> ilas_octet[7:5] == 3'h1)
    else $error("revision field wrong");
  cs_zero_a: assert property (ilas_valid && idx_reg == 4'h7 |-> ilas_octet[7:5] == 3'h0)
    else $error("control bits field not zero");
  lcnt_oct_a: assert property (ilas_valid && idx_reg == 4'h3
    |-> ilas_octet[4:0] == {1'h0, lane_count - 4'h1}) else $error("lane count field wrong");
  last_pos_a: assert property (ilas_valid |-> ilas_last == (idx_reg == 4'hd))
    else $error("last flag misplaced");
  pll_cause_a: assert property ($changed(pll_mult_x16) && !$past(reset) && !$past(reset, 2)
    |-> $past(avs_write, 2)) else $error("rate factor moved without a write");
endmodule // jlp_link_param_chk

// ---- testbench/jlp_ilas_sink.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Receiving end of the alignment octets
// ----------------------------------------------------------------
module jlp_ilas_sink (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic [7:0] ilas_octet, // Octet
  input wire logic [2:0] ilas_lane, // Lane
  input wire logic ilas_last, // Last octet
  input wire logic ilas_valid, // Present
  output logic ilas_ready, // Taken
  input wire logic stall // Throttle intake
);
  logic [1:0] ph_reg;
  logic [11:0] cap [0:127];
  int cnt;

  // Slow mode takes one octet in four so the FIFO backs up
  assign ilas_ready = !reset && (!stall || ph_reg == 2'h0);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ph_reg <= 2'h0;
      cnt <= 0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      if (ilas_valid && ilas_ready) begin
        cap[cnt % 128] <= {ilas_lane, ilas_last, ilas_octet};
        cnt <= cnt + 1;
      end
    end
  end
endmodule // jlp_ilas_sink

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic clk_sys, reset, avs_read, avs_write, avs_waitrequest, ilas_last, ilas_valid, ilas_ready;
  logic enc_64b66b, mode_valid, stall;
  logic [7:0] avs_address, ilas_octet;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, lane_count;
  logic [2:0] ilas_lane;
  logic [9:0] pll_mult_x16;
  int fails, checks;
  // ----------------------------------------------------------------
  // Mode table: {N', N, S, F, M, L}, rate x16, long-encoding map
  // ----------------------------------------------------------------
  logic [31:0] pa [16] = '{32'h0c0c5888, 32'h0c0c2246, 32'h08081144, 32'h0a0a4544, 32'h0c0c1243, 32'h08081242,
    32'h0c0c2246, 32'h08081144, 32'h0c0c2344, 32'h08082148, 32'h0a0a4588, 32'h0, 32'h0, 32'h0, 32'h0c0c2388, 32'h0};
  logic [9:0] r16 [16] = '{10'h080, 10'h0a0, 10'h0a0, 10'h0c8, 10'h108, 10'h108, 10'h084, 10'h084, 10'h0c6, 10'h050,
    10'h064, 10'h0, 10'h0, 10'h0, 10'h063, 10'h0};
  logic [15:0] enc_map = 16'h41f0;

  jlp_link_param DUT (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ilas_octet(ilas_octet), .ilas_lane(ilas_lane),
    .ilas_last(ilas_last), .ilas_valid(ilas_valid), .ilas_ready(ilas_ready), .pll_mult_x16(pll_mult_x16),
    .lane_count(lane_count), .enc_64b66b(enc_64b66b), .mode_valid(mode_valid));
  jlp_ilas_sink u_sink (.clk_sys(clk_sys), .reset(reset), .ilas_octet(ilas_octet), .ilas_lane(ilas_lane),
    .ilas_last(ilas_last), .ilas_valid(ilas_valid), .ilas_ready(ilas_ready), .stall(stall));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  task end_of_test;
    $display("Mismatches %0d of %0d comparisons", fails, checks);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at an edge
  task bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_write <= is_wr;
    avs_read <= !is_wr;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'h0) break;
    end
    q = avs_readdata;
    if (i == 20) begin
      fails++;
      end_of_test();
    end
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk_sys);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask

  task rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
  endtask

  function automatic logic [7:0] exp_oct(input int m, input int lid, input int idx, input logic [7:0] did,
    input logic [7:0] kmf, input logic scr);
    logic [31:0] p;
    p = pa[m];
    case (idx)
      0: return did;
      2: return 8'(lid);
      3: return {scr, 2'h0, 5'(p[3:0] - 1)};
      4: return 8'(p[11:8] - 1);
      5: return kmf;
      6: return 8'(p[7:4] - 1);
      7: return 8'(p[20:16] - 1);
      8: return {3'h1, 5'(p[28:24] - 1)};
      9: return {3'h1, 5'(p[15:12] - 1)};
      13: return 8'(did + lid + scr + kmf + p[3:0] + p[11:8] + p[7:4] + p[20:16] + p[28:24] + p[15:12] - 4);
      default: return 8'h00;
    endcase
  endfunction

  task t_regs;
    rd(8'h00);
    chk(q, 32'h0);
    rd(8'h04);
    chk(q, 32'h1f);
    rd(8'h0c);
    chk(q, {16'h0, exp_oct(0, 0, 13, 8'h00, 8'h1f, 1'h0), 8'h01});
    avs_byteenable <= 4'h0;
    wr(8'h08, 32'h33);
    avs_byteenable <= 4'hf;
    wr(8'h0c, 32'hff);
    wr(8'h20, 32'hff);
    rd(8'h08);
    chk(q, 32'h0);
    rd(8'h20);
    chk(q, 32'h0);
    rd(8'h0c);
    chk(q[7:0], 8'h01);
  endtask

  task t_modes;
    int m;
    logic [8:0] k;
    wr(8'h04, 32'h0f);
    for (m = 0; m < 16; m++) begin
      wr(8'h00, m);
      @(posedge clk_sys);
      k = enc_map[m] ? 9'(256 / pa[m][11:8] - 1) : 9'h00f;
      chk({mode_valid, enc_64b66b, lane_count, pll_mult_x16}, {pa[m] != 0, enc_map[m], pa[m][3:0], r16[m]});
      rd(8'h10);
      chk(q, pa[m]);
      rd(8'h14);
      if (pa[m] != 0) chk(q & 32'h01ff03ff, {7'h0, k, 6'h0, r16[m]});
      if (enc_map[m]) chk(q[31:28], 4'h1);
      rd(8'h0c);
      chk(q[1:0], {enc_map[m], pa[m] != 0});
    end
  endtask

  task t_ilas(input int m, input logic [7:0] did, input logic [7:0] kmf, input logic scr, input logic st);
    int base, i, ln, ix;
    wr(8'h04, kmf);
    wr(8'h08, did);
    wr(8'h00, {scr, 4'(m)});
    stall <= st;
    base = u_sink.cnt;
    wr(8'h00, {1'h1, 2'h0, scr, 4'(m)});
    // Refused while the octets are still being pushed
    wr(8'h08, 32'h77);
    for (i = 0; i < 3000 && u_sink.cnt != base + 14 * pa[m][3:0]; i++) @(posedge clk_sys);
    if (i == 3000) begin
      fails++;
      end_of_test();
    end
    for (ln = 0; ln < pa[m][3:0]; ln++) begin
      for (ix = 0; ix < 14; ix++) begin
        i = (base + ln * 14 + ix) % 128;
        chk(u_sink.cap[i], {3'(ln), ix == 13, exp_oct(m, ln, ix, did, kmf, scr)});
      end
    end
    stall <= 1'h0;
    rd(8'h0c);
    chk(q[15:0], {exp_oct(m, 0, 13, did, kmf, scr), 8'h01});
    rd(8'h08);
    chk(q, {24'h0, did});
  endtask

  task t_enc64;
    int base;
    base = u_sink.cnt;
    wr(8'h00, 32'h05);
    wr(8'h00, 32'h85);
    repeat (20) @(posedge clk_sys);
    chk(u_sink.cnt, base);
    rd(8'h0c);
    chk(q[3:0], 4'hb);
    wr(8'h00, 32'h0c);
    wr(8'h00, 32'h8c);
    repeat (20) @(posedge clk_sys);
    chk(u_sink.cnt, base);
    rd(8'h0c);
    chk(q[2:0], 3'h0);
  endtask

  initial begin
    reset = 1'h1;
    avs_address = 8'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    stall = 1'h0;
    fails = 0;
    checks = 0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    t_regs;
    t_modes;
    t_ilas(0, 8'h5a, 8'h03, 1'h1, 1'h1);
    t_ilas(2, 8'ha5, 8'h1f, 1'h0, 1'h0);
    t_enc64;
    end_of_test;
  end
endmodule // tb

bind jlp_link_param jlp_link_param_chk u_chk (.clk_sys(clk_sys), .reset(reset), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .ilas_octet(ilas_octet), .ilas_lane(ilas_lane),
  .ilas_last(ilas_last), .ilas_valid(ilas_valid), .ilas_ready(ilas_ready), .pll_mult_x16(pll_mult_x16),
  .lane_count(lane_count), .enc_64b66b(enc_64b66b));
